// ==== hw/flash_status_cfg.svh ====
// constants for the flash write-status poller
`ifndef FLASH_STATUS_CFG_SVH
`define FLASH_STATUS_CFG_SVH
`define BIT_POLL         7
`define BIT_TOGGLE_A     6
`define BIT_TIMING_LIMIT 5
`define BIT_ERASE_WINDOW 3
`define BIT_TOGGLE_B     2
`define CMD_RESET        8'hf0
`define CMD_SUSPEND      8'hb0
`define ERASE_GAP_US     50
`define CLK_MHZ          20
// longest gap between sector erase commands in clocks, less one as the gap count starts at zero
`define ERASE_GAP_CYC    ((`ERASE_GAP_US * `CLK_MHZ) - 1)
`endif

// ==== hw/flash_status_pkg.sv ====
// types for the flash write-status poller
package flash_status_pkg;
    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_READ1   = 4'h1,
        ST_READ2   = 4'h2,
        ST_DECIDE  = 4'h3,
        ST_READ3   = 4'h4,
        ST_READ4   = 4'h5,
        ST_RECHECK = 4'h6,
        ST_RESET   = 4'h7,
        ST_WIN     = 4'h8
    } poll_state_t;
    typedef enum logic [1:0] {
        RES_NONE = 2'h0,
        RES_DONE = 2'h1,
        RES_FAIL = 2'h2,
        RES_LATE = 2'h3
    } poll_result_t;
endpackage

// ==== hw/flash_bus_cycle.sv ====
// one asynchronous-flash read or write cycle timed by clock counts
`timescale 1ns/1ps
`include "flash_status_cfg.svh"
module flash_bus_cycle #(
    parameter int AW = 22,
    parameter int DW = 16,
    parameter int PULSE_CYC = 2
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          start,
    input  wire logic          write,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic               done,
    output logic [DW-1:0]      rdata,
    output logic [AW-1:0]      flash_addr,
    output logic               chip_select_n,
    output logic               output_enable_n,
    output logic               write_strobe_n,
    input  wire logic [DW-1:0] flash_dq_in,
    output logic [DW-1:0]      flash_dq_out,
    output logic               flash_dq_oe
);
    logic [7:0] cnt_r;
    logic       busy_r;
    logic       wr_r;

    // strobe phase: each cycle closes so the device sees a fresh read (toggle bits advance)
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_r          <= 1'b0;
            wr_r            <= 1'b0;
            cnt_r           <= 8'h00;
            chip_select_n   <= 1'b1;
            output_enable_n <= 1'b1;
            write_strobe_n  <= 1'b1;
            flash_dq_oe     <= 1'b0;
            flash_dq_out    <= '0;
            flash_addr      <= '0;
        end else if (start && !busy_r) begin
            busy_r          <= 1'b1;
            wr_r            <= write;
            cnt_r           <= 8'(PULSE_CYC);
            flash_addr      <= addr;
            flash_dq_out    <= wdata;
            flash_dq_oe     <= write;
            chip_select_n   <= 1'b0;
            output_enable_n <= write;
            write_strobe_n  <= !write;
        end else if (busy_r) begin
            if (cnt_r == 8'h00) begin
                busy_r          <= 1'b0;
                chip_select_n   <= 1'b1;
                output_enable_n <= 1'b1;
                write_strobe_n  <= 1'b1; // rising edge ends the write
                flash_dq_oe     <= 1'b0;
            end else begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end

    // follow the bus while the read strobe is low, so the word standing at done was
    // sampled a clock earlier and is usable on the done edge; needs PULSE_CYC of 1 or more
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else if (busy_r && !wr_r) begin
            rdata <= flash_dq_in;
        end
    end

    assign done = busy_r && (cnt_r == 8'h00);
endmodule // flash_bus_cycle

// ==== hw/flash_status_poller.sv ====
// host-side poller of flash program/erase status bits
// Summary of operation
// - host times reads with output enable
// - begin with two back-to-back full-byte reads
// - no toggle: done, next read is data
// - toggling plus limit flag: recheck, else read again
// - resumed polling restarts from first double read
// - after failure host writes reset command
// - fast command spacing needs no window check
// - check window flag before and after command (the poller checks it before only)
// - host reads status at a valid address
// - host addresses the busy bank for status
`timescale 1ns/1ps
`include "flash_status_cfg.svh"
module flash_status_poller
    import flash_status_pkg::*;
#(
    parameter int AW = 22,
    parameter int DW = 16,
    parameter int PULSE_CYC = 2
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          poll_start,
    input  wire logic          poll_abort,
    input  wire logic [AW-1:0] poll_addr,
    input  wire logic          erase_cmd_start,
    input  wire logic [AW-1:0] erase_cmd_addr,
    input  wire logic [7:0]    erase_cmd_data,
    output logic               poll_busy,
    output logic               poll_done,
    output poll_result_t       poll_result,
    output logic [DW-1:0]      last_status,
    output logic               ready_seen,
    output logic               window_gap_late,
    output logic [AW-1:0]      flash_addr,
    output logic               chip_select_n,
    output logic               output_enable_n,
    output logic               write_strobe_n,
    input  wire logic [DW-1:0] flash_dq_in,
    output logic [DW-1:0]      flash_dq_out,
    output logic               flash_dq_oe,
    input  wire logic          ready_busy_in
);
    poll_state_t  state_r;
    poll_result_t result_r;
    logic         first_a_r;
    logic         first_b_r;
    logic         cyc_start;
    logic         cyc_write;
    logic         cyc_done;
    logic [AW-1:0] cyc_addr;
    logic [DW-1:0] cyc_wdata;
    logic [DW-1:0] rd;
    logic [AW-1:0] addr_r;
    logic          issued_r;
    logic [15:0]   gap_r;
    logic          gap_run_r;
    logic          win_pre_r;

    // toggle test on toggle bits 6 and 2 of two back-to-back reads
    function automatic logic toggled(input logic a, input logic b, input logic [DW-1:0] d);
        toggled = (a != d[`BIT_TOGGLE_A]) || (b != d[`BIT_TOGGLE_B]);
    endfunction

    flash_bus_cycle #(.AW(AW), .DW(DW), .PULSE_CYC(PULSE_CYC)) u_cycle (
        .clk             (clk),
        .rst             (rst),
        .start           (cyc_start),
        .write           (cyc_write),
        .addr            (cyc_addr),
        .wdata           (cyc_wdata),
        .done            (cyc_done),
        .rdata           (rd),
        .flash_addr      (flash_addr),
        .chip_select_n   (chip_select_n),
        .output_enable_n (output_enable_n),
        .write_strobe_n  (write_strobe_n),
        .flash_dq_in     (flash_dq_in),
        .flash_dq_out    (flash_dq_out),
        .flash_dq_oe     (flash_dq_oe)
    );

    // one bus cycle per state that needs it; write only for reset and window command
    assign cyc_write = (state_r == ST_RESET) || (state_r == ST_WIN);
    // no read is launched while leaving, or a later poll would take it as its own
    assign cyc_start = !issued_r && (state_r != ST_IDLE) && (state_r != ST_DECIDE)
                       && (state_r != ST_RECHECK) && !(state_r == ST_READ1 && poll_abort);
    assign cyc_addr  = (state_r == ST_WIN) ? erase_cmd_addr : addr_r;
    assign cyc_wdata = (state_r == ST_WIN) ? DW'(erase_cmd_data) : DW'(`CMD_RESET);

    // issued flag keeps a single cycle per state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            issued_r <= 1'b0;
        end else if (cyc_done) begin
            issued_r <= 1'b0;
        end else if (cyc_start) begin
            issued_r <= 1'b1;
        end
    end

    // polling sequence
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r   <= ST_IDLE;
            result_r  <= RES_NONE;
            addr_r    <= '0;
            first_a_r <= 1'b0;
            first_b_r <= 1'b0;
            poll_done <= 1'b0;
            win_pre_r <= 1'b0;
        end else begin
            poll_done <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    if (erase_cmd_start) begin
                        addr_r  <= erase_cmd_addr;
                        state_r <= ST_WIN;
                    end else if (poll_start) begin
                        addr_r  <= poll_addr;
                        state_r <= ST_READ1;
                    end
                end
                ST_WIN: begin
                    if (cyc_done) begin
                        addr_r  <= erase_cmd_addr;
                        state_r <= ST_READ1;
                    end
                end
                ST_READ1: begin
                    if (poll_abort && !issued_r) begin
                        state_r <= ST_IDLE;
                    end else if (cyc_done) begin
                        first_a_r <= rd[`BIT_TOGGLE_A];
                        first_b_r <= rd[`BIT_TOGGLE_B];
                        state_r   <= ST_READ2;
                    end
                end
                ST_READ2: begin
                    if (cyc_done) begin
                        state_r <= ST_DECIDE;
                    end
                end
                ST_DECIDE: begin
                    if (!toggled(first_a_r, first_b_r, rd)) begin
                        result_r  <= RES_DONE;
                        poll_done <= 1'b1;
                        state_r   <= ST_IDLE;
                    end else if (rd[`BIT_TIMING_LIMIT]) begin
                        state_r <= ST_READ3;
                    end else if (poll_abort) begin
                        state_r <= ST_IDLE;
                    end else begin
                        state_r <= ST_READ1;
                    end
                end
                ST_READ3: begin
                    if (cyc_done) begin
                        first_a_r <= rd[`BIT_TOGGLE_A];
                        first_b_r <= rd[`BIT_TOGGLE_B];
                        state_r   <= ST_READ4;
                    end
                end
                ST_READ4: begin
                    if (cyc_done) begin
                        state_r <= ST_RECHECK;
                    end
                end
                ST_RECHECK: begin
                    if (toggled(first_a_r, first_b_r, rd)) begin
                        state_r <= ST_RESET;
                    end else begin
                        result_r  <= RES_DONE;
                        poll_done <= 1'b1;
                        state_r   <= ST_IDLE;
                    end
                end
                ST_RESET: begin
                    if (cyc_done) begin
                        result_r  <= RES_FAIL;
                        poll_done <= 1'b1;
                        state_r   <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
            // window flag before the next sector command, taken from the last status read before it
            if (state_r == ST_IDLE && erase_cmd_start) begin
                win_pre_r <= last_status[`BIT_ERASE_WINDOW];
            end else if (state_r == ST_IDLE && poll_start) begin
                win_pre_r <= 1'b0; // a plain poll sends no command
            end
        end
    end

    // status word and ready level as last seen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_status <= '0;
            ready_seen  <= 1'b0;
        end else begin
            if (cyc_done && !cyc_write) begin
                last_status <= rd;
            end
            ready_seen <= ready_busy_in;
        end
    end

    // spacing between sector erase commands; late means the window may have closed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_r           <= 16'h0000;
            gap_run_r       <= 1'b0;
            window_gap_late <= 1'b0;
        end else if (state_r == ST_IDLE && erase_cmd_start) begin
            window_gap_late <= gap_run_r && (gap_r >= 16'(`ERASE_GAP_CYC));
            gap_r           <= 16'h0000;
            gap_run_r       <= 1'b1;
        end else if (gap_run_r && gap_r != 16'hffff) begin
            gap_r <= gap_r + 16'h0001;
        end
    end

    // result reports a rejected command when the window had already closed
    assign poll_result = (result_r == RES_DONE && win_pre_r) ? RES_LATE : result_r;
    assign poll_busy   = (state_r != ST_IDLE);
endmodule // flash_status_poller

// ==== verif/flash_poll_chk.sv ====
// assertions on the ports of the flash status poller
`timescale 1ns/1ps
`include "flash_status_cfg.svh"
module flash_poll_chk
    import flash_status_pkg::*;
#(
    parameter int AW = 22,
    parameter int DW = 16,
    parameter int PULSE_CYC = 2
) (
    input wire logic          clk,
    input wire logic          rst,
    input wire logic          poll_start,
    input wire logic          poll_abort,
    input wire logic          erase_cmd_start,
    input wire logic          poll_busy,
    input wire logic          poll_done,
    input wire poll_result_t  poll_result,
    input wire logic [DW-1:0] last_status,
    input wire logic          chip_select_n,
    input wire logic          output_enable_n,
    input wire logic          write_strobe_n,
    input wire logic [DW-1:0] flash_dq_out,
    input wire logic          flash_dq_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [1:0] n_rd_r;
    logic       rst_seen_r;
    // read cycles since the last accepted request, saturating at three
    always_ff @(posedge clk or posedge rst) begin
        if (rst) n_rd_r <= 2'h0;
        else if ((poll_start || erase_cmd_start) && !poll_busy) n_rd_r <= 2'h0;
        else if ($rose(output_enable_n) && n_rd_r != 2'h3) n_rd_r <= n_rd_r + 2'h1;
    end
    // reset command seen since the last accepted request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) rst_seen_r <= 1'b0;
        else if ((poll_start || erase_cmd_start) && !poll_busy) rst_seen_r <= 1'b0;
        else if (!write_strobe_n && flash_dq_out[7:0] == `CMD_RESET) rst_seen_r <= 1'b1;
    end
    sequence rd_hold;
        !output_enable_n [*3] ##1 output_enable_n;
    endsequence
    read_len_a: assert property ($fell(output_enable_n) |-> rd_hold)
        else $error("read strobe length wrong");
    write_drive_a: assert property (!write_strobe_n |-> flash_dq_oe && output_enable_n)
        else $error("write without driven data");
    start_read_a: assert property (poll_start && !poll_busy && !erase_cmd_start |->
        ##[1:3] (!chip_select_n && !output_enable_n))
        else $error("poll did not open a read");
    two_reads_a: assert property (poll_done && poll_result != RES_NONE |-> n_rd_r >= 2'h2)
        else $error("verdict before two reads");
    done_pulse_a: assert property (poll_done |=> !poll_done)
        else $error("done longer than one cycle");
    done_clean_a: assert property (poll_done && poll_result == RES_DONE |-> !rst_seen_r)
        else $error("reset written on success");
    fail_reset_a: assert property (poll_done && poll_result == RES_FAIL |-> rst_seen_r)
        else $error("failure without reset command");
    fail_flag_a: assert property (poll_done && poll_result == RES_FAIL |->
        last_status[`BIT_TIMING_LIMIT])
        else $error("failure without limit flag");
    abort_exit_a: assert property (poll_abort && poll_busy |-> ##[0:24] !poll_busy)
        else $error("abort not honoured");
endmodule // flash_poll_chk
bind flash_status_poller flash_poll_chk #(.AW(AW), .DW(DW), .PULSE_CYC(PULSE_CYC)) chk_u (.*);

// ==== verif/flash_dev_model.sv ====
// behavioural flash bank answering status polls and commands
`timescale 1ns/1ps
`include "flash_status_cfg.svh"
module flash_dev_model #(
    parameter int AW = 22,
    parameter int DW = 16,
    parameter logic [15:0] ARRAY_WORD = 16'h3c52
) (
    input  wire logic [AW-1:0] flash_addr,
    input  wire logic          chip_select_n,
    input  wire logic          output_enable_n,
    input  wire logic          write_strobe_n,
    input  wire logic [DW-1:0] flash_dq_out,
    output logic      [DW-1:0] flash_dq_in,
    output logic               ready_busy_in
);
    int            busy_left = 0; // reads left; 1000 or more never ends
    logic          fail = 1'b0;
    logic          tog = 1'b0;
    int            win_cnt = 0;
    logic [DW-1:0] w_data = '0;
    logic [AW-1:0] w_addr = '0;
    logic [DW-1:0] word;
    logic          rd_on;
    logic          wr_on;
    assign rd_on = !output_enable_n && !chip_select_n;
    assign wr_on = !write_strobe_n && !chip_select_n;
    assign ready_busy_in = !(busy_left > 0);
    // status while busy, array data once back in read mode
    assign word = (busy_left > 0) ? {8'h00, 1'b0, tog, fail, 1'b0, win_cnt >= 2, tog, 2'b00}
                                  : ARRAY_WORD;
    // a released bus shows the inverse of its last value, and flips again on each change of word
    initial flash_dq_in = '0;
    always @(rd_on or word) begin
        if (rd_on) flash_dq_in = word;
        else flash_dq_in = ~flash_dq_in;
    end
    // both toggle bits advance as each read cycle ends
    always @(negedge rd_on) if (busy_left > 0) begin
        tog = ~tog;
        if (busy_left < 1000) busy_left--;
        if (win_cnt < 2) win_cnt++;
    end
    // data latched while the write is open, because strobes and data change together
    always @(*) if (wr_on) begin
        w_data = flash_dq_out;
        w_addr = flash_addr;
    end
    always @(negedge wr_on) begin
        if (w_data[7:0] == `CMD_RESET) begin
            busy_left = 0;
            fail = 1'b0;
        end else if (busy_left == 0 || win_cnt < 2) begin
            busy_left = 3;
            win_cnt = 0;
            fail = 1'b0; // a fresh operation starts without a limit failure
        end
    end
endmodule // flash_dev_model

// ==== verif/tb.sv ====
// self-checking bench for the flash status poller
`timescale 1ns/1ps
`include "flash_status_cfg.svh"
module tb
    import flash_status_pkg::*;
;
    localparam int AW = 22;
    localparam int DW = 16;
    localparam logic [AW-1:0] SECT = 22'h0a0000;
    localparam logic [15:0] AWORD = 16'h3c52;
    localparam logic [7:0] ERASE_CODE = 8'h30; // command byte the model takes as erase
    logic          clk = 1'b0, rst = 1'b1, poll_start = 1'b0, poll_abort = 1'b0;
    logic          erase_cmd_start = 1'b0;
    logic [AW-1:0] poll_addr = SECT, erase_cmd_addr = SECT, flash_addr;
    logic [7:0]    erase_cmd_data = ERASE_CODE;
    logic          poll_busy, poll_done, ready_seen, window_gap_late, chip_select_n;
    logic          output_enable_n, write_strobe_n, flash_dq_oe, ready_busy_in;
    poll_result_t  poll_result;
    logic [DW-1:0] last_status, flash_dq_in, flash_dq_out;
    int            n_fail = 0, check_count = 0;
    flash_status_poller dut_u (.*);
    flash_dev_model #(.ARRAY_WORD(AWORD)) dev_u (.*);
    task automatic end_sim();
        if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bounded wait, sampled just after the edge so its updates have landed
    task automatic wait_for(ref logic s, input logic v);
        int i;
        for (i = 0; i < 400 && s !== v; i++) begin
            @(posedge clk);
            #1;
        end
        if (s !== v) begin
            n_fail++;
            end_sim();
        end
    endtask
    task automatic poll(input int busy, input logic fl, input poll_result_t res);
        dev_u.busy_left = busy;
        dev_u.fail = fl;
        @(posedge clk) poll_start <= 1'b1;
        @(posedge clk) poll_start <= 1'b0;
        wait_for(poll_done, 1'b1);
        chk(poll_result, res);
    endtask
    task automatic erase(input poll_result_t res);
        @(posedge clk) erase_cmd_start <= 1'b1;
        @(posedge clk) erase_cmd_start <= 1'b0;
        wait_for(poll_done, 1'b1);
        chk(poll_result, res);
        chk(dev_u.w_data[7:0], ERASE_CODE);
    endtask
    initial forever #25 clk = ~clk;
    initial begin
        repeat (20) @(posedge clk);
        #1 chk({poll_busy, chip_select_n, output_enable_n, write_strobe_n, flash_dq_oe}, 5'h0e);
        @(posedge clk) rst <= 1'b0;
        poll(0, 1'b0, RES_DONE);
        chk(last_status, AWORD);
        poll(3, 1'b0, RES_DONE);
        poll(2, 1'b1, RES_DONE);
        chk(last_status, AWORD);
        erase(RES_DONE);
        erase(RES_DONE);
        chk(window_gap_late, 1'b0);
        repeat (1100) @(posedge clk);
        erase(RES_DONE);
        chk(window_gap_late, 1'b1);
        // leave a long poll midway; the abort leaves no reset command written
        dev_u.busy_left = 1000;
        dev_u.fail = 1'b0;
        @(posedge clk) poll_start <= 1'b1;
        @(posedge clk) poll_start <= 1'b0;
        repeat (30) @(posedge clk);
        #1 chk(ready_seen, 1'b0);
        @(posedge clk) poll_abort <= 1'b1;
        wait_for(poll_busy, 1'b0);
        @(posedge clk) poll_abort <= 1'b0;
        chk(dev_u.w_data[7:0], ERASE_CODE);
        // window already closed: the next sector command is refused and reported late
        dev_u.busy_left = 2;
        erase(RES_LATE);
        poll(0, 1'b0, RES_DONE);
        chk(ready_seen, 1'b1);
        poll(1000, 1'b1, RES_FAIL);
        chk(last_status[`BIT_TIMING_LIMIT], 1'b1);
        chk(dev_u.w_data[7:0], `CMD_RESET);
        chk(dev_u.w_addr, SECT);
        poll(0, 1'b0, RES_DONE);
        end_sim();
    end
endmodule // tb
